// >>> shared/nvrtc_pkg.sv
// Constants, register map and carrier types for the byte-wide timekeeping RAM.
// Assumes a single 25 MHz clock, mclk, and a synchronous active-high reset.
package nvrtc_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned RAM_DEPTH = 2040;
  localparam logic [10:0] CENTURY_CONTROL = 11'h7f8;
  localparam logic [10:0] SECONDS_COUNT = 11'h7f9;
  localparam logic [10:0] MINUTES_COUNT = 11'h7fa;
  localparam logic [10:0] HOURS_COUNT = 11'h7fb;
  localparam logic [10:0] WEEKDAY_FLAGS = 11'h7fc;
  localparam logic [10:0] DATE_OF_MONTH = 11'h7fd;
  localparam logic [10:0] MONTH_COUNT = 11'h7fe;
  localparam logic [10:0] YEAR_COUNT = 11'h7ff;
  // Field positions
  localparam int unsigned WRITE_HOLD_BIT = 7;
  localparam int unsigned READ_HOLD_BIT = 6;
  localparam int unsigned OSC_STOP_BIT = 7;
  localparam int unsigned BATTERY_BIT = 7;
  localparam int unsigned FREQ_TEST_BIT = 6;
  // Field masks of used bits
  localparam logic [7:0] MASK_CENTURY = 8'h3f;
  localparam logic [7:0] MASK_SECONDS = 8'h7f;
  localparam logic [7:0] MASK_MINUTES = 8'h7f;
  localparam logic [7:0] MASK_HOURS = 8'h3f;
  localparam logic [7:0] MASK_DAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  // Reset values of the clock fields
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_ONE = 8'h01;
  // Timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TEST_HZ = 512;
  localparam int unsigned TEST_HALF_CYCLES = CLK_HZ / (TEST_HZ * 2);
  localparam int unsigned SECOND_CYCLES = CLK_HZ;
  localparam int unsigned ADDRESS_ACCESS_TIME_NS = 70;
  localparam int unsigned OUTPUT_HOLD_TIME_NS = 5;
  localparam int unsigned STROBE_TO_OUTPUT_OFF_TIME_NS = 25;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [3:0] ACCESS_CYCLES =
    4'((ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYCLES =
    4'((OUTPUT_HOLD_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : OUTPUT_HOLD_TIME_NS / CLK_PERIOD_NS);
  // Calendar, one byte per field
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } nvrtc_time_t;
  // Host bus pins after synchronising
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
    logic select_n;
    logic out_en_n;
    logic strobe_n;
  } nvrtc_bus_t;
endpackage

// >>> verilog/nvrtc_calendar.sv
// One-second step of the packed BCD calendar.
// Assumes the inputs hold legal BCD; the step is purely combinational.
`timescale 1ns/1ns
`default_nettype none
module nvrtc_calendar (
  // Time now and time one second later
  input wire nvrtc_pkg::nvrtc_time_t now_time,
  output nvrtc_pkg::nvrtc_time_t next_time
);
  // BCD increment with wrap to a low value
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] low);
    logic [7:0] r;
    r = low;
    if (v != top)
    begin
      if (v[3:0] == 4'h9)
        r = {v[7:4] + 4'h1, 4'h0};
      else
        r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Leap year: BCD year divisible by four
  wire leap = ((now_time.year[4] == 1'b0) && (now_time.year[1:0] == 2'b00)) ||
              ((now_time.year[4] == 1'b1) && (now_time.year[1:0] == 2'b10));
  logic [7:0] month_end;
  // Month length with leap correction
  always_comb
  begin
    case (now_time.month)
      8'h02: month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  end
  wire sec_wrap = (now_time.seconds == 8'h59);
  wire min_wrap = sec_wrap && (now_time.minutes == 8'h59);
  wire hour_wrap = min_wrap && (now_time.hours == 8'h23);
  wire date_wrap = hour_wrap && (now_time.date == month_end);
  wire mon_wrap = date_wrap && (now_time.month == 8'h12);
  wire year_wrap = mon_wrap && (now_time.year == 8'h99);
  // Ripple of carries through every field
  always_comb
  begin
    next_time = now_time;
    next_time.seconds = bcd_step(now_time.seconds, 8'h59, 8'h00);
    if (sec_wrap)
      next_time.minutes = bcd_step(now_time.minutes, 8'h59, 8'h00);
    if (min_wrap)
      next_time.hours = bcd_step(now_time.hours, 8'h23, 8'h00);
    if (hour_wrap)
    begin
      next_time.day = bcd_step(now_time.day, 8'h07, 8'h01);
      next_time.date = bcd_step(now_time.date, month_end, 8'h01);
    end
    if (date_wrap)
      next_time.month = bcd_step(now_time.month, 8'h12, 8'h01);
    if (mon_wrap)
      next_time.year = bcd_step(now_time.year, 8'h99, 8'h00);
    if (year_wrap)
      next_time.century = bcd_step(now_time.century, 8'h39, 8'h00);
  end
endmodule // nvrtc_calendar
`default_nettype wire

// >>> verilog/nvrtc_top.sv
// Byte-wide timekeeping RAM: host bus slave, calendar counters, byte RAM.
// Assumes host pins are asynchronous to mclk and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module nvrtc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host bus pins
  input wire logic [10:0] addr,
  input wire logic select_n,
  input wire logic out_en_n,
  input wire logic strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic data_valid,
  // Supply monitor
  input wire logic power_fail,
  input wire logic battery_ok,
  // Observed timekeeping state
  output logic osc_running
);
  // Two-stage synchronisers for every pin input
  // Two edges of latency buy safe sampling of raw pins; every access
  // window below is counted from the synchronised copy.
  nvrtc_pkg::nvrtc_bus_t pin_bus, meta_bus, bus;
  logic [1:0] meta_sup, sup;
  assign pin_bus = '{addr: addr, data: data_in, select_n: select_n,
                     out_en_n: out_en_n, strobe_n: strobe_n};
  always_ff @(posedge mclk)
  begin
    meta_bus <= pin_bus;
    bus <= meta_bus;
    meta_sup <= {power_fail, battery_ok};
    sup <= meta_sup;
  end
  wire pf = sup[1];
  wire batt = sup[0];

  // Access decode
  // Power fail gates both decodes, so a sagging supply can neither
  // corrupt a byte nor turn the data drivers on.
  wire rd_act = !bus.select_n && !bus.out_en_n && bus.strobe_n && !pf;
  wire wr_act = !bus.select_n && !bus.strobe_n && !pf;
  wire is_clock = (bus.addr >= nvrtc_pkg::CENTURY_CONTROL);
  logic wr_prev;
  wire wr_start = wr_act && !wr_prev; // Later falling edge of select or strobe

  // Live counters and user-visible copy
  // The host only sees the visible copy, so a read never catches a carry
  // in mid-ripple; the cost is a second set of eight bytes.
  // The live copy keeps counting under read hold; write hold and the stop bit halt it.
  nvrtc_pkg::nvrtc_time_t live, shown, stepped;
  logic write_hold, read_hold, osc_stop, freq_test;
  logic [24:0] sec_cnt;
  logic [15:0] test_cnt;
  logic test_bit;
  logic refresh_due;

  nvrtc_calendar u_calendar (
    .now_time(live),
    .next_time(stepped)
  );

  wire osc_run = !osc_stop;
  wire sec_tick = osc_run && (sec_cnt == 25'(nvrtc_pkg::SECOND_CYCLES - 1));
  wire test_tick = osc_run && (test_cnt == 16'(nvrtc_pkg::TEST_HALF_CYCLES - 1));

  // Oscillator divider; stop bit clears both prescalers and holds them at zero
  // Plain binary prescalers on mclk; accuracy is that of mclk itself,
  // there is no trimming.
  always_ff @(posedge mclk)
  begin
    if (rst || !osc_run)
      sec_cnt <= '0;
    else
      sec_cnt <= sec_tick ? '0 : sec_cnt + 25'h0000001;
  end
  always_ff @(posedge mclk)
  begin
    if (rst || !osc_run || !freq_test)
      test_cnt <= '0;
    else
      test_cnt <= test_tick ? '0 : test_cnt + 16'h0001;
  end
  // 512 Hz square wave on the seconds LSB
  always_ff @(posedge mclk)
  begin
    if (rst || !freq_test)
      test_bit <= 1'b0;
    else if (test_tick)
      test_bit <= !test_bit;
  end

  // Mask host data to the used bits; unused bits are forced to zero here
  // Dropping unused bits keeps a careless host from pushing a field
  // out of its BCD range through them.
  function automatic logic [7:0] field_mask(input logic [2:0] idx);
    case (idx)
      3'd0: field_mask = nvrtc_pkg::MASK_CENTURY;
      3'd1: field_mask = nvrtc_pkg::MASK_SECONDS;
      3'd2: field_mask = nvrtc_pkg::MASK_MINUTES;
      3'd3: field_mask = nvrtc_pkg::MASK_HOURS;
      3'd4: field_mask = nvrtc_pkg::MASK_DAY;
      3'd5: field_mask = nvrtc_pkg::MASK_DATE;
      3'd6: field_mask = nvrtc_pkg::MASK_MONTH;
      default: field_mask = 8'hff;
    endcase
  endfunction
  wire [2:0] reg_idx = bus.addr[2:0];
  wire [7:0] wdata = bus.data & field_mask(reg_idx);
  wire clk_wr = wr_start && is_clock;

  // Control bits live outside the time fields
  // They act at once, without write hold, so stop and frequency test
  // can be flipped on a running clock.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      write_hold <= 1'b0;
      read_hold <= 1'b0;
      osc_stop <= 1'b0;
      freq_test <= 1'b0;
    end
    else if (clk_wr)
    begin
      if (bus.addr == nvrtc_pkg::CENTURY_CONTROL)
      begin
        write_hold <= bus.data[nvrtc_pkg::WRITE_HOLD_BIT];
        read_hold <= bus.data[nvrtc_pkg::READ_HOLD_BIT];
      end
      if (bus.addr == nvrtc_pkg::SECONDS_COUNT)
        osc_stop <= bus.data[nvrtc_pkg::OSC_STOP_BIT];
      if (bus.addr == nvrtc_pkg::WEEKDAY_FLAGS)
        freq_test <= bus.data[nvrtc_pkg::FREQ_TEST_BIT]; // Battery bit ignored
    end
  end

  // Writes land in the visible copy; clearing write hold loads the live counters
  wire load_live = clk_wr && (bus.addr == nvrtc_pkg::CENTURY_CONTROL) &&
                   write_hold && !bus.data[nvrtc_pkg::WRITE_HOLD_BIT];
  always_ff @(posedge mclk)
  begin
    if (rst)
      live <= '{century: nvrtc_pkg::RESET_ZERO, year: nvrtc_pkg::RESET_ZERO,
                month: nvrtc_pkg::RESET_ONE, date: nvrtc_pkg::RESET_ONE,
                day: nvrtc_pkg::RESET_ONE, hours: nvrtc_pkg::RESET_ZERO,
                minutes: nvrtc_pkg::RESET_ZERO, seconds: nvrtc_pkg::RESET_ZERO};
    else if (load_live)
      live <= {wdata, shown[55:0]}; // Century from the clearing write
    else if (sec_tick && !write_hold)
      live <= stepped; // Counting continues under read hold
  end

  // Visible copy: frozen under either hold, refreshed on the next tick, or on the next edge once read hold clears
  // Limitation: field writes without write hold are dropped, since the
  // next refresh would overwrite them anyway.
  wire hold_any = write_hold || read_hold;
  // Control byte that raises write hold also lands its century
  wire set_hold = (reg_idx == 3'd0) && bus.data[nvrtc_pkg::WRITE_HOLD_BIT];
  wire shown_wr = clk_wr && (write_hold || set_hold);
  always_ff @(posedge mclk)
  begin
    if (rst)
      refresh_due <= 1'b0;
    else if (read_hold)
      refresh_due <= 1'b1;
    else if (sec_tick || !osc_run)
      refresh_due <= 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      shown <= '0;
    else if (shown_wr)
    begin
      case (reg_idx)
        3'd0: shown.century <= wdata;
        3'd1: shown.seconds <= wdata;
        3'd2: shown.minutes <= wdata;
        3'd3: shown.hours <= wdata;
        3'd4: shown.day <= wdata;
        3'd5: shown.date <= wdata;
        3'd6: shown.month <= wdata;
        default: shown.year <= wdata;
      endcase
    end
    else if (!hold_any && (sec_tick || refresh_due || load_live))
      shown <= live; // Within one second of read hold clearing
    else if (!hold_any && !osc_run)
      shown <= live;
  end

  // Byte RAM below the clock bytes; contents survive power fail
  // Registered read port; the access counter below covers its one cycle
  // of latency, so the byte is always ready when shown.
  logic [7:0] ram [0:nvrtc_pkg::RAM_DEPTH-1];
  logic [7:0] ram_q;
  always_ff @(posedge mclk)
  begin
    if (wr_start && !is_clock)
      ram[bus.addr] <= bus.data;
    ram_q <= ram[bus.addr];
  end

  // Clock register read selection
  // Control and day bytes merge live flags with stored fields; the
  // battery flag is never stored, only sampled.
  logic [7:0] clk_q;
  always_comb
  begin
    case (reg_idx)
      3'd0: clk_q = {write_hold, read_hold, shown.century[5:0]};
      3'd1: clk_q = {osc_stop, shown.seconds[6:1],
                     freq_test ? test_bit : shown.seconds[0]}; // Live toggle
      3'd2: clk_q = shown.minutes;
      3'd3: clk_q = shown.hours;
      3'd4: clk_q = {batt, freq_test, shown.day[5:0]}; // Read-only flag
      3'd5: clk_q = shown.date;
      3'd6: clk_q = shown.month;
      default: clk_q = shown.year;
    endcase
  end
  logic is_clock_q;
  wire [7:0] read_byte = is_clock_q ? clk_q : ram_q;

  // Access timing: count cycles since address or enables last changed
  // Access times round up to whole mclk periods, so reads are never
  // faster than the pin figures, only slower.
  logic [10:0] addr_prev;
  logic [3:0] settle_cnt;
  logic [3:0] hold_cnt;
  logic [7:0] last_good;
  wire addr_moved = (bus.addr != addr_prev);
  wire settled = (settle_cnt >= nvrtc_pkg::ACCESS_CYCLES);
  // Edge memory for write start and address change
  always_ff @(posedge mclk)
  begin
    addr_prev <= bus.addr;
    is_clock_q <= is_clock;
    wr_prev <= rst ? 1'b0 : wr_act;
  end
  // Address access time restarts on every address change or new read
  always_ff @(posedge mclk)
  begin
    if (rst || !rd_act || addr_moved)
      settle_cnt <= '0;
    else if (!settled)
      settle_cnt <= settle_cnt + 4'h1;
  end
  // Output hold after an address change
  // Arms only when a settled byte exists to hold
  always_ff @(posedge mclk)
  begin
    if (rst || !rd_act)
      hold_cnt <= '0;
    else if (addr_moved && settled)
      hold_cnt <= nvrtc_pkg::HOLD_CYCLES;
    else if (hold_cnt != 4'h0)
      hold_cnt <= hold_cnt - 4'h1;
  end

  // Output pins: driven only on select and output enable
  // Undefined phases show all ones with valid low rather than an
  // unknown, so a host can tell them from stale data.
  wire drive = !bus.select_n && !bus.out_en_n && bus.strobe_n && !pf;
  wire show_good = rd_act && settled && !addr_moved;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
      data_valid <= 1'b0;
      last_good <= 8'h00;
      osc_running <= 1'b0;
    end
    else
    begin
      data_oe_n <= !drive; // Strobe fall turns drivers off next edge
      osc_running <= osc_run;
      if (show_good)
      begin
        data_out <= read_byte; // Follows address without a new strobe
        last_good <= read_byte;
        data_valid <= 1'b1;
      end
      else if (rd_act && (hold_cnt != 4'h0 || (addr_moved && settled)))
      begin
        data_out <= last_good; // Previous byte held briefly
        data_valid <= 1'b1;
      end
      else
      begin
        data_out <= 8'hff; // Undefined phase shown as ff
        data_valid <= 1'b0;
      end
    end
  end
endmodule // nvrtc_top
`default_nettype wire

// >>> sim/nvrtc_top_assertions.sv
// Checker for the host-bus side of the timekeeping RAM.
// Assumes it is bound to nvrtc_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module nvrtc_top_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host bus
  input wire logic [10:0] addr,
  input wire logic select_n,
  input wire logic out_en_n,
  input wire logic strobe_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic data_valid,
  // Supply and state
  input wire logic power_fail,
  input wire logic battery_ok,
  input wire logic osc_running
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Read condition at the pins, three edges of synchroniser and output flop
  wire read_pins = !select_n && !out_en_n && strobe_n && !power_fail;
  AST_OE_CAUSE: assert property (!data_oe_n |-> $past(read_pins, 3))
    else $error("data driven without a read");
  AST_OE_ON: assert property (read_pins [*5] |-> !data_oe_n)
    else $error("read not driven");
  AST_DESELECT: assert property (select_n [*5] |-> data_oe_n)
    else $error("driven while deselected");
  AST_VALID_DRIVEN: assert property (data_valid |-> !data_oe_n)
    else $error("valid while not driving");
  AST_UNDEF_PATTERN: assert property ((!data_valid && !data_oe_n) |-> data_out == 8'hff)
    else $error("undefined data not ff");
  AST_NOT_EARLY: assert property ($fell(data_oe_n) |-> !data_valid)
    else $error("valid before access time");
  AST_VALID_WITHIN: assert property ($fell(data_oe_n) |-> ##[1:6] (data_valid || data_oe_n))
    else $error("read data late");
  AST_ADDR_CHANGE: assert property (($changed(addr) && data_valid) |=> $stable(data_out) ##[0:5] !data_valid)
    else $error("address change handling wrong");
  AST_STROBE_OFF: assert property ((!strobe_n) [*5] |-> data_oe_n)
    else $error("driven during write strobe");
  AST_POWER_FAIL: assert property (power_fail [*5] |-> data_oe_n)
    else $error("driven under power fail");
  // Main scenarios reached
  cover property (data_valid && !data_oe_n);
  cover property ($changed(addr) && data_valid);
  cover property (power_fail && !select_n && !out_en_n);
endmodule // nvrtc_top_assertions
bind nvrtc_top nvrtc_top_assertions u_chk (.mclk(mclk), .rst(rst), .addr(addr),
  .select_n(select_n), .out_en_n(out_en_n), .strobe_n(strobe_n), .data_in(data_in),
  .data_out(data_out), .data_oe_n(data_oe_n), .data_valid(data_valid),
  .power_fail(power_fail), .battery_ok(battery_ok), .osc_running(osc_running));
`default_nettype wire

// >>> sim/nvrtc_host_model.sv
// Host side of the asynchronous byte bus, with read and write tasks.
// Assumes it shares mclk with the device and changes pins after rising edges.
`timescale 1ns/1ns
`default_nettype none
module nvrtc_host_model (
  // Clock
  input wire logic mclk,
  // Pins driven by the host
  output logic [10:0] addr,
  output logic select_n,
  output logic out_en_n,
  output logic strobe_n,
  output logic [7:0] data_in,
  // Pins driven by the device
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic data_valid
);
  initial
  begin
    addr = 11'h000;
    select_n = 1'b1;
    out_en_n = 1'b1;
    strobe_n = 1'b1;
    data_in = 8'h00;
  end
  // Write with output enable high, so the bus never fights the device
  task automatic write_byte(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    data_in <= d;
    select_n <= 1'b0;
    strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    select_n <= 1'b1;
    strobe_n <= 1'b1;
    data_in <= ~d; // Released lines show no stale byte
    repeat (2) @(posedge mclk);
  endtask
  task automatic open_read(input logic [10:0] a);
    @(posedge mclk);
    addr <= a;
    select_n <= 1'b0;
    out_en_n <= 1'b0;
  endtask
  // Bounded wait, a hang shows up as ok low
  task automatic wait_valid(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    repeat (20)
    begin
      @(posedge mclk);
      if (data_valid === 1'b1 && data_oe_n === 1'b0)
      begin
        d = data_out;
        ok = 1'b1;
        break;
      end
    end
  endtask
  // Ripple read: new address with select and enable held
  task automatic move_read(input logic [10:0] a, output logic [7:0] d, output logic ok);
    @(posedge mclk);
    addr <= a;
    repeat (8)
    begin
      @(posedge mclk);
      if (data_valid !== 1'b1)
        break;
    end
    wait_valid(d, ok);
  endtask
  task automatic close_read();
    @(posedge mclk);
    select_n <= 1'b1;
    out_en_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic read_byte(input logic [10:0] a, output logic [7:0] d, output logic ok);
    open_read(a);
    wait_valid(d, ok);
    close_read();
  endtask
endmodule // nvrtc_host_model
`default_nettype wire

// >>> sim/nvrtc_top_bench.sv
// Self-checking bench for the timekeeping RAM through its byte bus.
// Assumes the host model file and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module nvrtc_top_bench;
  logic mclk;
  logic rst;
  logic power_fail;
  logic battery_ok;
  logic [10:0] addr;
  logic select_n;
  logic out_en_n;
  logic strobe_n;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe_n;
  logic data_valid;
  logic osc_running;
  int num_errors;
  int total_checks;
  logic [7:0] d;
  logic ok;
  logic tog;
  // Field values at the top of each range, unused bits zero
  logic [7:0] field_val [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0] field_exp [7] = '{8'h59, 8'h59, 8'h23, 8'h87, 8'h31, 8'h12, 8'h99};
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  nvrtc_top dut (.mclk(mclk), .rst(rst), .addr(addr), .select_n(select_n),
    .out_en_n(out_en_n), .strobe_n(strobe_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_valid(data_valid), .power_fail(power_fail),
    .battery_ok(battery_ok), .osc_running(osc_running));
  nvrtc_host_model host (.mclk(mclk), .addr(addr), .select_n(select_n),
    .out_en_n(out_en_n), .strobe_n(strobe_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_valid(data_valid));
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Held seconds read, watching bit zero for one half period of the test tone
  task automatic watch_toggle(output logic t);
    logic [7:0] v;
    logic k;
    host.open_read(11'h7f9);
    host.wait_valid(v, k);
    t = 1'b0;
    repeat (nvrtc_pkg::TEST_HALF_CYCLES + 16)
    begin
      @(posedge mclk);
      if (data_valid === 1'b1 && data_out[0] !== v[0])
        t = 1'b1;
    end
    host.close_read();
  endtask
  // Watchdog sized above the two tone watches
  initial
  begin
    repeat (80000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    power_fail = 1'b0;
    battery_ok = 1'b1;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    host.write_byte(11'h000, 8'h5a);
    host.write_byte(11'h7f7, 8'ha5);
    host.read_byte(11'h000, d, ok);
    check8("ram low", 8'h5a, d);
    host.open_read(11'h7f7);
    host.wait_valid(d, ok);
    check8("ripple first", 8'ha5, d);
    host.move_read(11'h000, d, ok);
    check8("ripple second", 8'h5a, d);
    host.close_read();
    power_fail <= 1'b1;
    repeat (4) @(posedge mclk);
    host.write_byte(11'h000, 8'h33);
    host.read_byte(11'h000, d, ok);
    check8("drive under power fail", 8'h00, {7'h00, ok});
    power_fail <= 1'b0;
    repeat (4) @(posedge mclk);
    host.read_byte(11'h000, d, ok);
    check8("ram kept", 8'h5a, d);
    host.write_byte(11'h7f8, 8'hb9);
    for (int i = 0; i < 7; i++)
      host.write_byte(11'(11'h7f9 + i), field_val[i]);
    for (int i = 0; i < 7; i++)
    begin
      host.read_byte(11'(11'h7f9 + i), d, ok);
      check8("clock field", field_exp[i], d);
    end
    host.read_byte(11'h7f8, d, ok);
    check8("century control", 8'hb9, d);
    battery_ok <= 1'b0;
    repeat (4) @(posedge mclk);
    host.write_byte(11'h7fc, 8'h87);
    host.read_byte(11'h7fc, d, ok);
    check8("flag exhausted", 8'h07, d);
    battery_ok <= 1'b1;
    repeat (4) @(posedge mclk);
    host.read_byte(11'h7fc, d, ok);
    check8("flag healthy", 8'h87, d);
    host.write_byte(11'h7f8, 8'h00);
    host.write_byte(11'h7f8, 8'h40);
    host.read_byte(11'h7f8, d, ok);
    check8("read hold bit", 8'h40, d);
    host.write_byte(11'h7f8, 8'h00);
    host.read_byte(11'h7ff, d, ok);
    check8("live loaded", 8'h99, d);
    host.write_byte(11'h7fc, 8'h47);
    watch_toggle(tog);
    check8("tone running", 8'h01, {7'h00, tog});
    host.write_byte(11'h7f9, 8'h80);
    check8("osc stopped", 8'h00, {7'h00, osc_running});
    watch_toggle(tog);
    check8("tone stopped", 8'h00, {7'h00, tog});
    host.write_byte(11'h7f9, 8'h00);
    check8("osc restarted", 8'h01, {7'h00, osc_running});
    finish_test();
  end
endmodule // nvrtc_top_bench
`default_nettype wire
